// [core/peirq_top.sv]
// peripheral interrupt enable and priority registers with two-level request routing
// assumes flags are set and cleared by peripheral logic and software on the same clock
`timescale 1ns/1ps

module peirq_top
    import peirq_pkg::*;
(
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst_n,
    input  wire peirq_pkg::peirq_axil_req_t i_axil,
    output peirq_pkg::peirq_axil_rsp_t    o_axil,
    input  wire peirq_pkg::peirq_bank_t   i_flags,
    input  wire peirq_pkg::peirq_ext_t    i_ext_enable,
    input  wire peirq_pkg::peirq_ext_t    i_ext_priority,
    output logic                          o_irq_high,
    output logic                          o_irq_low,
    output logic                          o_irq
);
    import peirq_pkg::*;

    peirq_core_t             s;
    peirq_core_t             n;
    logic                    wr_en;
    logic [`PEIRQ_IDX_W-1:0] wr_idx;
    logic [31:0]             wr_data;
    logic [3:0]              wr_strb;
    logic                    wr_err;
    logic                    rd_en;
    logic [`PEIRQ_IDX_W-1:0] rd_idx;
    logic [31:0]             rd_data;
    logic                    rd_err;
    peirq_bank_t             en_all;
    peirq_bank_t             pr_all;
    peirq_bank_t             hi_vec;
    peirq_bank_t             lo_vec;
    logic                    any_high;
    logic                    any_low;
    logic [1:0]              st_set;
    logic [1:0]              st_clr;
    peirq_byte_t             wbyte;

    peirq_axil_slave u_slave (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_axil    (i_axil),
        .o_axil    (o_axil),
        .o_wr_en   (wr_en),
        .o_wr_idx  (wr_idx),
        .o_wr_data (wr_data),
        .o_wr_strb (wr_strb),
        .i_wr_err  (wr_err),
        .o_rd_en   (rd_en),
        .o_rd_idx  (rd_idx),
        .i_rd_data (rd_data),
        .i_rd_err  (rd_err)
    );

    // flags are only read here; clearing them is up to software
    for (genvar g = 0; g < 8; g++) begin : g_grp
        if (g < 3) begin : g_en_ext
            assign en_all[g] = i_ext_enable[g];
        end else begin : g_en_loc
            assign en_all[g] = s.ena[g];
        end
        if (g > 4) begin : g_pr_ext
            assign pr_all[g] = i_ext_priority[g-5];
        end else begin : g_pr_loc
            assign pr_all[g] = s.prio[g];
        end
        peirq_route #(
            .W (8)
        ) u_route (
            .i_flag     (i_flags[g]),
            .i_enable   (en_all[g]),
            .i_priority (pr_all[g]),
            .o_req_high (hi_vec[g]),
            .o_req_low  (lo_vec[g])
        );
    end

    assign any_high = |hi_vec;
    assign any_low  = |lo_vec;

    function automatic logic idx_ok(input logic [`PEIRQ_IDX_W-1:0] idx);
        unique case (idx)
            `PEIRQ_IDX_PRIO0, `PEIRQ_IDX_PRIO1, `PEIRQ_IDX_PRIO2,
            `PEIRQ_IDX_PRIO3, `PEIRQ_IDX_PRIO4,
            `PEIRQ_IDX_ENA3, `PEIRQ_IDX_ENA4, `PEIRQ_IDX_ENA5,
            `PEIRQ_IDX_ENA6, `PEIRQ_IDX_ENA7,
            `PEIRQ_IDX_STATUS, `PEIRQ_IDX_MASK: idx_ok = 1'b1;
            default: idx_ok = 1'b0;
        endcase
    endfunction : idx_ok

    assign wr_err = ~idx_ok(wr_idx);
    assign rd_err = ~idx_ok(rd_idx);

    // read mux, upper bits zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_idx)
            `PEIRQ_IDX_PRIO0:  rd_data[7:0] = s.prio[0];
            `PEIRQ_IDX_PRIO1:  rd_data[7:0] = s.prio[1];
            `PEIRQ_IDX_PRIO2:  rd_data[7:0] = s.prio[2];
            `PEIRQ_IDX_PRIO3:  rd_data[7:0] = s.prio[3];
            `PEIRQ_IDX_PRIO4:  rd_data[7:0] = s.prio[4];
            `PEIRQ_IDX_ENA3:   rd_data[7:0] = s.ena[3];
            `PEIRQ_IDX_ENA4:   rd_data[7:0] = s.ena[4];
            `PEIRQ_IDX_ENA5:   rd_data[7:0] = s.ena[5];
            `PEIRQ_IDX_ENA6:   rd_data[7:0] = s.ena[6];
            `PEIRQ_IDX_ENA7:   rd_data[7:0] = s.ena[7];
            `PEIRQ_IDX_STATUS: rd_data[1:0] = s.status;
            `PEIRQ_IDX_MASK:   rd_data[1:0] = s.mask;
            default:           rd_data = 32'h0000_0000;
        endcase
    end

    assign wbyte  = wr_data[7:0];
    assign st_clr = (rd_en && rd_idx == `PEIRQ_IDX_STATUS) ? `PEIRQ_MSK_STAT : 2'h0;
    assign st_set = {any_low & ~s.prev_low, any_high & ~s.prev_high};

    always_comb begin
        n = s;
        if (wr_en && wr_strb[0]) begin
            case (wr_idx)
                `PEIRQ_IDX_ENA3:  n.ena[3]  = wbyte & `PEIRQ_MSK_ENA3;
                `PEIRQ_IDX_ENA4:  n.ena[4]  = wbyte & `PEIRQ_MSK_ENA4;
                `PEIRQ_IDX_ENA5:  n.ena[5]  = wbyte & `PEIRQ_MSK_ENA5;
                `PEIRQ_IDX_ENA6:  n.ena[6]  = wbyte & `PEIRQ_MSK_ENA6;
                `PEIRQ_IDX_ENA7:  n.ena[7]  = wbyte & `PEIRQ_MSK_ENA7;
                `PEIRQ_IDX_PRIO0: n.prio[0] = wbyte & `PEIRQ_MSK_PRIO0;
                `PEIRQ_IDX_PRIO1: n.prio[1] = wbyte & `PEIRQ_MSK_PRIO1;
                `PEIRQ_IDX_PRIO2: n.prio[2] = wbyte & `PEIRQ_MSK_PRIO2;
                `PEIRQ_IDX_PRIO3: n.prio[3] = wbyte & `PEIRQ_MSK_PRIO3;
                `PEIRQ_IDX_PRIO4: n.prio[4] = wbyte & `PEIRQ_MSK_PRIO4;
                `PEIRQ_IDX_MASK:  n.mask    = wbyte[1:0];
                default:          n.mask    = s.mask;
            endcase
        end
        // a new request in the clearing read cycle still sets its bit
        n.status    = (s.status & ~st_clr) | st_set;
        n.prev_high = any_high;
        n.prev_low  = any_low;
        n.irq_high  = any_high;
        n.irq_low   = any_low;
        n.irq       = |(n.status & n.mask);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s         <= '0;
            s.ena     <= {5{`PEIRQ_RST_ENA}};
            s.prio[0] <= `PEIRQ_RST_PRIO0;
            s.prio[1] <= `PEIRQ_RST_PRIO1;
            s.prio[2] <= `PEIRQ_RST_PRIO2;
            s.prio[3] <= `PEIRQ_RST_PRIO3;
            s.prio[4] <= `PEIRQ_RST_PRIO4;
            s.status  <= `PEIRQ_RST_STAT;
        end else begin
            s <= n;
        end
    end

    assign o_irq_high = s.irq_high;
    assign o_irq_low  = s.irq_low;
    assign o_irq      = s.irq;
endmodule : peirq_top

// [core/peirq_defs.svh]
// register indices, reset values and implemented-bit masks of the irq enable/priority block
// assumes inclusion by bare name from the package
`ifndef PEIRQ_DEFS_SVH
`define PEIRQ_DEFS_SVH

`define PEIRQ_ADDR_W      16
`define PEIRQ_IDX_W       14

// register indices, byte address is four times the index
`define PEIRQ_IDX_PRIO0   14'h0EBA
`define PEIRQ_IDX_PRIO1   14'h0EBB
`define PEIRQ_IDX_PRIO2   14'h0EBC
`define PEIRQ_IDX_PRIO3   14'h0EBD
`define PEIRQ_IDX_PRIO4   14'h0EBE
`define PEIRQ_IDX_ENA3    14'h0EC5
`define PEIRQ_IDX_ENA4    14'h0EC6
`define PEIRQ_IDX_ENA5    14'h0EC7
`define PEIRQ_IDX_ENA6    14'h0EC8
`define PEIRQ_IDX_ENA7    14'h0EC9
`define PEIRQ_IDX_STATUS  14'h0F00
`define PEIRQ_IDX_MASK    14'h0F01

// reset values
`define PEIRQ_RST_ENA     8'h00
`define PEIRQ_RST_PRIO0   8'h31
`define PEIRQ_RST_PRIO1   8'hC3
`define PEIRQ_RST_PRIO2   8'hC3
`define PEIRQ_RST_PRIO3   8'h33
`define PEIRQ_RST_PRIO4   8'h3F
`define PEIRQ_RST_STAT    2'h0

// implemented bits
`define PEIRQ_MSK_ENA3    8'hFF
`define PEIRQ_MSK_ENA4    8'h3F
`define PEIRQ_MSK_ENA5    8'h07
`define PEIRQ_MSK_ENA6    8'h03
`define PEIRQ_MSK_ENA7    8'hE1
`define PEIRQ_MSK_PRIO0   8'h37
`define PEIRQ_MSK_PRIO1   8'hC3
`define PEIRQ_MSK_PRIO2   8'hC3
`define PEIRQ_MSK_PRIO3   8'hFF
`define PEIRQ_MSK_PRIO4   8'h3F
`define PEIRQ_MSK_STAT    2'h3

// status bit positions
`define PEIRQ_STAT_HIGH   0
`define PEIRQ_STAT_LOW    1

// axi responses
`define PEIRQ_RESP_OKAY   2'h0
`define PEIRQ_RESP_SLVERR 2'h2

`endif

// [core/peirq_pkg.sv]
// types of the irq enable/priority block
// assumes the defs header is on the include path
`include "peirq_defs.svh"

package peirq_pkg;

    typedef logic [7:0]          peirq_byte_t;
    typedef peirq_byte_t [7:0]   peirq_bank_t;
    typedef peirq_byte_t [2:0]   peirq_ext_t;

    typedef struct packed {
        logic                      awvalid;
        logic [`PEIRQ_ADDR_W-1:0]  awaddr;
        logic                      wvalid;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bready;
        logic                      arvalid;
        logic [`PEIRQ_ADDR_W-1:0]  araddr;
        logic                      rready;
    } peirq_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } peirq_axil_rsp_t;

    typedef struct packed {
        logic                     aw_held;
        logic                     w_held;
        logic [`PEIRQ_IDX_W-1:0]  awidx;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } peirq_slv_t;

    typedef struct packed {
        peirq_byte_t [7:3] ena;
        peirq_byte_t [4:0] prio;
        logic [1:0]        status;
        logic [1:0]        mask;
        logic              irq_high;
        logic              irq_low;
        logic              irq;
        logic              prev_high;
        logic              prev_low;
    } peirq_core_t;

endpackage : peirq_pkg

// [core/peirq_route.sv]
// gates one group of peripheral flags by their enables and splits them by priority
// assumes flags, enables and priorities come from logic on the same clock
`timescale 1ns/1ps

module peirq_route #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_flag,
    input  wire logic [W-1:0] i_enable,
    input  wire logic [W-1:0] i_priority,
    output logic      [W-1:0] o_req_high,
    output logic      [W-1:0] o_req_low
);
    logic [W-1:0] req;

    assign req        = i_flag & i_enable;
    assign o_req_high = req & i_priority;
    assign o_req_low  = req & ~i_priority;
endmodule : peirq_route

// [core/peirq_axil_slave.sv]
// axi4-lite slave front end: one write and one read in flight, byte strobes to the core
// assumes the core answers read data and decode errors combinationally from the index
`timescale 1ns/1ps

module peirq_axil_slave
    import peirq_pkg::*;
(
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst_n,
    input  wire peirq_pkg::peirq_axil_req_t i_axil,
    output peirq_pkg::peirq_axil_rsp_t    o_axil,
    output logic                          o_wr_en,
    output logic [`PEIRQ_IDX_W-1:0]       o_wr_idx,
    output logic [31:0]                   o_wr_data,
    output logic [3:0]                    o_wr_strb,
    input  wire logic                     i_wr_err,
    output logic                          o_rd_en,
    output logic [`PEIRQ_IDX_W-1:0]       o_rd_idx,
    input  wire logic [31:0]              i_rd_data,
    input  wire logic                     i_rd_err
);
    peirq_slv_t s;
    peirq_slv_t n;

    assign o_wr_en   = s.aw_held & s.w_held & ~s.bvalid;
    assign o_wr_idx  = s.awidx;
    assign o_wr_data = s.wdata;
    assign o_wr_strb = s.wstrb;
    assign o_rd_en   = i_axil.arvalid & ~s.rvalid;
    assign o_rd_idx  = i_axil.araddr[`PEIRQ_ADDR_W-1:2];

    always_comb begin
        o_axil         = '0;
        o_axil.awready = ~s.aw_held;
        o_axil.wready  = ~s.w_held;
        o_axil.bvalid  = s.bvalid;
        o_axil.bresp   = s.bresp;
        o_axil.arready = ~s.rvalid;
        o_axil.rvalid  = s.rvalid;
        o_axil.rdata   = s.rdata;
        o_axil.rresp   = s.rresp;
    end

    always_comb begin
        n = s;
        if (i_axil.awvalid && !s.aw_held) begin
            n.aw_held = 1'b1;
            n.awidx   = i_axil.awaddr[`PEIRQ_ADDR_W-1:2];
        end
        if (i_axil.wvalid && !s.w_held) begin
            n.w_held = 1'b1;
            n.wdata  = i_axil.wdata;
            n.wstrb  = i_axil.wstrb;
        end
        if (o_wr_en) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = i_wr_err ? `PEIRQ_RESP_SLVERR : `PEIRQ_RESP_OKAY;
        end else if (s.bvalid && i_axil.bready) begin
            n.bvalid = 1'b0;
        end
        if (o_rd_en) begin
            n.rvalid = 1'b1;
            n.rdata  = i_rd_data;
            n.rresp  = i_rd_err ? `PEIRQ_RESP_SLVERR : `PEIRQ_RESP_OKAY;
        end else if (s.rvalid && i_axil.rready) begin
            n.rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : peirq_axil_slave

// [bench/peirq_partner.sv]
// model of the peripheral event sources feeding the flag inputs
// assumes events and software clears arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps

module peirq_partner
    import peirq_pkg::*;
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_n,
    input  wire peirq_pkg::peirq_bank_t i_event,
    input  wire peirq_pkg::peirq_bank_t i_clear,
    output peirq_pkg::peirq_bank_t      o_flags
);
    // flags are set by events and stay until software clears them
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flags <= '0;
        end else begin
            o_flags <= (o_flags & ~i_clear) | i_event;
        end
    end
endmodule : peirq_partner

// [bench/peirq_properties.sv]
// checker of bus answers and request routing at the top ports
// assumes one clock domain and a bind onto every peirq_top
`timescale 1ns/1ps
`include "peirq_defs.svh"

module peirq_properties
    import peirq_pkg::*;
(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    input  wire peirq_pkg::peirq_axil_req_t i_axil,
    input  wire peirq_pkg::peirq_axil_rsp_t o_axil,
    input  wire peirq_pkg::peirq_bank_t     i_flags,
    input  wire logic                       o_irq_high,
    input  wire logic                       o_irq_low
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_bresp_hold: assert property (o_axil.bvalid && !i_axil.bready
        |=> o_axil.bvalid && $stable(o_axil.bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (o_axil.rvalid && !i_axil.rready
        |=> o_axil.rvalid && $stable(o_axil.rdata)) else $error("read answer dropped");
    a_read_answer: assert property (i_axil.arvalid && o_axil.arready
        |=> o_axil.rvalid) else $error("read not answered");
    a_write_answer: assert property (i_axil.awvalid && o_axil.awready
        && i_axil.wvalid && o_axil.wready && !o_axil.bvalid |-> ##[1:3] o_axil.bvalid)
        else $error("write not answered");
    a_rdata_upper: assert property (o_axil.rvalid
        |-> o_axil.rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_slverr_zero: assert property (o_axil.rvalid
        && o_axil.rresp == `PEIRQ_RESP_SLVERR |-> o_axil.rdata == 32'h0000_0000)
        else $error("error read with data");
    a_irq_cause: assert property (o_irq_high || o_irq_low
        |-> $past(i_flags) != '0) else $error("request without flag");
    a_flags_quiet: assert property (i_flags == '0
        |=> !o_irq_high && !o_irq_low) else $error("request after flags cleared");
endmodule : peirq_properties

bind peirq_top peirq_properties u_chk (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_axil     (i_axil),
    .o_axil     (o_axil),
    .i_flags    (i_flags),
    .o_irq_high (o_irq_high),
    .o_irq_low  (o_irq_low)
);

// [bench/tb.sv]
// self-checking bench of the enable and priority registers and the request outputs
// assumes the checker is bound onto the design by its own file
`timescale 1ns/1ps
`include "peirq_defs.svh"

module tb;
    import peirq_pkg::*;
    logic            clk;
    logic            rst_n;
    peirq_axil_req_t ax;
    peirq_axil_rsp_t rs;
    peirq_bank_t     ev, clr, flags;
    peirq_ext_t      ext_en, ext_pr;
    logic            irq_h, irq_l, irq;
    logic [7:0]      seed;
    logic [1:0]      st;
    logic [33:0]     expq [$];
    int              fail_count, n_checks, i;
    logic [13:0] idx_t [10] = '{`PEIRQ_IDX_ENA3, `PEIRQ_IDX_ENA4, `PEIRQ_IDX_ENA5,
        `PEIRQ_IDX_ENA6, `PEIRQ_IDX_ENA7, `PEIRQ_IDX_PRIO0, `PEIRQ_IDX_PRIO1,
        `PEIRQ_IDX_PRIO2, `PEIRQ_IDX_PRIO3, `PEIRQ_IDX_PRIO4};
    logic [7:0] rst_t [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'hC3, 8'hC3,
        8'h33, 8'h3F};
    logic [7:0] msk_t [10] = '{8'hFF, 8'h3F, 8'h07, 8'h03, 8'hE1, 8'h37, 8'hC3, 8'hC3,
        8'hFF, 8'h3F};

    peirq_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_axil(ax), .o_axil(rs),
        .i_flags(flags), .i_ext_enable(ext_en), .i_ext_priority(ext_pr),
        .o_irq_high(irq_h), .o_irq_low(irq_l), .o_irq(irq));
    peirq_partner src (.i_clk_sys(clk), .i_rst_n(rst_n), .i_event(ev), .i_clear(clr),
        .o_flags(flags));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // one bus transfer, the expected answer is noted before it starts
    task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] d,
                       input logic [33:0] exp);
        int   n;
        logic a, w, b;
        expq.push_back(exp);
        @(posedge clk);
        ax.awvalid <= wr;
        ax.wvalid  <= wr;
        ax.bready  <= wr;
        ax.arvalid <= !wr;
        ax.rready  <= !wr;
        ax.awaddr  <= {idx, 2'b00};
        ax.araddr  <= {idx, 2'b00};
        ax.wdata   <= {24'h00_0000, d};
        ax.wstrb   <= 4'hF;
        n = 0;
        do begin
            @(negedge clk);
            a = wr ? rs.awready : rs.arready;
            w = rs.wready;
            b = wr ? rs.bvalid : rs.rvalid;
            @(posedge clk);
            if (a) begin
                ax.awvalid <= 1'b0;
                ax.arvalid <= 1'b0;
            end
            if (w) ax.wvalid <= 1'b0;
            if (b) begin
                ax.bready <= 1'b0;
                ax.rready <= 1'b0;
            end
            n++;
        end while (!b && n < 50);
        if (!b) begin
            fail_count++;
            summarize();
        end
    endtask : bus

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic flag(input int g, input int b, input logic set);
        @(posedge clk);
        if (set) ev[g][b] <= 1'b1;
        else clr[g][b] <= 1'b1;
        @(posedge clk);
        ev  <= '0;
        clr <= '0;
        settle();
    endtask : flag

    // answers are compared against the oldest note
    always @(posedge clk) begin
        if (rs.bvalid && ax.bready) check({rs.bresp, 32'h0000_0000}, expq.pop_front());
        if (rs.rvalid && ax.rready) check({rs.rresp, rs.rdata}, expq.pop_front());
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        ax = '0;
        ev = '0;
        clr = '0;
        ext_en = '0;
        ext_pr = '0;
        rst_n = 1'b0;
        seed = 8'h23;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 10; i++) bus(0, idx_t[i], 8'h00, {26'h000_0000, rst_t[i]});
        for (i = 0; i < 10; i++) begin
            bus(1, idx_t[i], 8'hFF, 34'h0);
            bus(0, idx_t[i], 8'h00, {26'h000_0000, msk_t[i]});
            seed = lfsr(seed);
            bus(1, idx_t[i], seed, 34'h0);
            bus(0, idx_t[i], 8'h00, {26'h000_0000, seed & msk_t[i]});
        end
        bus(1, 14'h0100, 8'hFF, {`PEIRQ_RESP_SLVERR, 32'h0000_0000});
        bus(0, 14'h0100, 8'h00, {`PEIRQ_RESP_SLVERR, 32'h0000_0000});
        for (i = 1; i < 5; i++) bus(1, idx_t[i], 8'h00, 34'h0);
        st = 2'h0;
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bus(1, `PEIRQ_IDX_ENA3, 8'h01 << i, 34'h0);
            bus(1, `PEIRQ_IDX_PRIO3, seed, 34'h0);
            flag(3, i, 1'b1);
            check({32'h0000_0000, irq_h, irq_l}, {32'h0000_0000, seed[i], !seed[i]});
            st = st | (seed[i] ? 2'h1 : 2'h2);
            bus(1, `PEIRQ_IDX_ENA3, ~(8'h01 << i), 34'h0);
            settle();
            check({32'h0000_0000, irq_h, irq_l}, 34'h0);
            flag(3, i, 1'b0);
        end
        bus(0, `PEIRQ_IDX_STATUS, 8'h00, {32'h0000_0000, st});
        bus(1, `PEIRQ_IDX_MASK, 8'h01, 34'h0);
        bus(1, `PEIRQ_IDX_ENA3, 8'h01, 34'h0);
        bus(1, `PEIRQ_IDX_PRIO3, 8'h01, 34'h0);
        flag(3, 0, 1'b1);
        check({33'h0_0000_0000, irq}, 34'h1);
        bus(0, `PEIRQ_IDX_STATUS, 8'h00, 34'h1);
        settle();
        check({33'h0_0000_0000, irq}, 34'h0);
        bus(1, `PEIRQ_IDX_MASK, 8'h00, 34'h0);
        bus(1, `PEIRQ_IDX_PRIO3, 8'h00, 34'h0);
        settle();
        check({32'h0000_0000, irq_h, irq_l, irq}, 34'h2);
        bus(1, `PEIRQ_IDX_MASK, 8'h02, 34'h0);
        settle();
        check({33'h0_0000_0000, irq}, 34'h1);
        bus(0, `PEIRQ_IDX_STATUS, 8'h00, 34'h2);
        flag(3, 0, 1'b0);
        bus(1, `PEIRQ_IDX_PRIO0, 8'h01, 34'h0);
        ext_en[0] <= 8'h01;
        flag(0, 0, 1'b1);
        check({32'h0000_0000, irq_h, irq_l}, 34'h2);
        flag(0, 0, 1'b0);
        // groups 4..7: bit 0 of each, priority from register 4 or the outside inputs
        ext_pr <= {8'h01, 8'h00, 8'h01};
        bus(1, `PEIRQ_IDX_PRIO4, 8'h00, 34'h0);
        for (i = 4; i < 8; i++) begin
            bus(1, idx_t[i-3], 8'h01, 34'h0);
            flag(i, 0, 1'b1);
            check({32'h0000_0000, irq_h, irq_l}, {32'h0000_0000, i[0], !i[0]});
            bus(1, idx_t[i-3], 8'h00, 34'h0);
            flag(i, 0, 1'b0);
        end
        // second reset in mid-run brings the priorities back
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `PEIRQ_IDX_PRIO3, 8'h00, {26'h000_0000, `PEIRQ_RST_PRIO3});
        bus(0, `PEIRQ_IDX_PRIO4, 8'h00, {26'h000_0000, `PEIRQ_RST_PRIO4});
        summarize();
    end
endmodule : tb
